// *** hdl/idle_line_detector.sv ***
// Idle line detector counting high bit times on the receive line
`timescale 1ns/10ps
`default_nettype none
module idle_line_detector (
  input  wire logic                             sys_clk,    // Clock
  input  wire logic                             rst,        // Async reset
  input  wire serial_status_pkg::rx_timing_t    rx_tim,     // Bit timing
  input  wire logic                             after_stop, // Count select
  input  wire logic                             long_char,  // Char length
  output var  logic                             idle_seen   // Idle pulse
);
  import serial_status_pkg::*;

  idle_state_t             state_ff;
  idle_state_t             nxt_state;
  logic [IDLE_CNT_W-1:0]   cnt_ff;
  logic [IDLE_CNT_W-1:0]   nxt_cnt;
  logic [IDLE_CNT_W-1:0]   threshold;
  logic                    high_tick;
  logic                    reached;

  assign threshold = long_char ? IDLE_BITS_LONG : IDLE_BITS_SHORT;
  assign high_tick = rx_tim.bit_tick & rx_tim.line;
  assign reached   = high_tick
                     & ((cnt_ff + IDLE_CNT_ONE) == threshold);
  assign idle_seen = (state_ff == IDLE_COUNT) & reached;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      IDLE_COUNT: begin
        if (reached) begin
          nxt_state = IDLE_DONE;
        end else if (high_tick) begin
          nxt_cnt = cnt_ff + IDLE_CNT_ONE;
        end else if (rx_tim.bit_tick) begin
          nxt_cnt = IDLE_CNT_ZERO;
        end
      end
      default: begin
      end
    endcase
    // Start bit restarts the count unless it must wait for stop bits
    if (rx_tim.start_bit) begin
      nxt_cnt   = IDLE_CNT_ZERO;
      nxt_state = after_stop ? IDLE_OFF : IDLE_COUNT;
    end else if (rx_tim.stop_done && after_stop
                 && state_ff == IDLE_OFF) begin
      nxt_cnt   = IDLE_CNT_ZERO;
      nxt_state = IDLE_COUNT;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_ff <= IDLE_OFF;
      cnt_ff   <= IDLE_CNT_ZERO;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

endmodule : idle_line_detector
`default_nettype wire

// *** hdl/serial_status_flags.sv ***
// Status flags, data buffers and interrupt logic of the serial port
//
// Chosen here: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module serial_status_flags (
  input  wire logic                          sys_clk,        // Clock
  input  wire logic                          rst,            // Async reset
  input  wire serial_status_pkg::reg_req_t   reg_req,        // Register req
  output var  logic [7:0]                    rd_data,        // Read data
  output var  logic                          irq,            // Interrupt
  output var  logic [7:0]                    tx_data,        // Tx buffer
  output var  logic                          tx_buf_full,    // Tx buf loaded
  input  wire logic                          tx_load,        // Shifter took
  input  wire logic                          tx_active,      // Shifting
  output var  logic                          tx_enable,      // Tx enable
  output var  logic                          preamble_queue, // Preamble req
  output var  logic                          break_request,  // Break level
  input  wire logic                          rx_char_valid,  // Char arrived
  input  wire logic [7:0]                    rx_char,        // Char value
  input  wire serial_status_pkg::rx_timing_t rx_tim          // Rx timing
);
  import serial_status_pkg::*;

  // ==========================================================================
  // Address decode
  logic sel_ctrl;
  logic sel_status;
  logic sel_data;
  logic sel_istat;
  logic sel_imask;
  logic sel_cfg;
  logic status_rd;
  logic data_wr;
  logic data_rd;
  logic ctrl_wr;
  logic istat_wr;
  logic imask_wr;
  logic cfg_wr;

  assign sel_ctrl   = reg_req.addr == CTRL_TWO_ADDR;
  assign sel_status = reg_req.addr == STATUS_ADDR;
  assign sel_data   = reg_req.addr == DATA_ADDR;
  assign sel_istat  = reg_req.addr == IRQ_STAT_ADDR;
  assign sel_imask  = reg_req.addr == IRQ_MASK_ADDR;
  assign sel_cfg    = reg_req.addr == CONFIG_ADDR;

  assign status_rd = reg_req.rd & sel_status;
  assign data_wr   = reg_req.wr & sel_data;
  assign data_rd   = reg_req.rd & sel_data;
  assign ctrl_wr   = reg_req.wr & sel_ctrl;
  assign istat_wr  = reg_req.wr & sel_istat;
  assign imask_wr  = reg_req.wr & sel_imask;
  assign cfg_wr    = reg_req.wr & sel_cfg;
  // A write to the status address decodes to nothing

  // ==========================================================================
  // Control, config and data storage
  logic             te_ff;
  logic             sbk_ff;
  logic             ilt_ff;
  logic             long_ff;
  logic [7:0]       tx_data_ff;
  logic [7:0]       rx_data_ff;
  logic             tx_full_ff;
  logic             tx_pend_ff;
  logic             preamble_ff;
  logic             te_rise;
  logic             sbk_wr;
  logic             nxt_te;
  logic             nxt_sbk;
  logic             nxt_tx_full;
  logic             nxt_tx_pend;

  assign nxt_te  = ctrl_wr ? reg_req.wdata[CTRL_TE_BIT] : te_ff;
  assign nxt_sbk = ctrl_wr ? reg_req.wdata[CTRL_SBK_BIT] : sbk_ff;
  // Enable going 0 to 1 queues a preamble
  assign te_rise = ctrl_wr & reg_req.wdata[CTRL_TE_BIT] & ~te_ff;
  assign sbk_wr  = ctrl_wr & reg_req.wdata[CTRL_SBK_BIT];

  // Buffer holds a value from data write until the shifter takes it
  assign nxt_tx_full = data_wr | (tx_full_ff & ~tx_load);
  // Queued preamble or break keeps complete low until shifting begins
  assign nxt_tx_pend = te_rise | sbk_wr | (tx_pend_ff & ~tx_active);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      te_ff      <= 1'b0;
      sbk_ff     <= 1'b0;
      tx_full_ff <= 1'b0;
      tx_pend_ff <= 1'b0;
    end else begin
      te_ff      <= nxt_te;
      sbk_ff     <= nxt_sbk;
      tx_full_ff <= nxt_tx_full;
      tx_pend_ff <= nxt_tx_pend;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ilt_ff  <= 1'b0;
      long_ff <= 1'b0;
    end else if (cfg_wr) begin
      ilt_ff  <= reg_req.wdata[CFG_ILT_BIT];
      long_ff <= reg_req.wdata[CFG_LONG_BIT];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_data_ff <= DATA_ZERO;
    end else if (data_wr) begin
      tx_data_ff <= reg_req.wdata;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_data_ff <= DATA_ZERO;
    end else if (rx_char_valid) begin
      rx_data_ff <= rx_char;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      preamble_ff <= 1'b0;
    end else begin
      preamble_ff <= te_rise;
    end
  end

  assign tx_data        = tx_data_ff;
  assign tx_buf_full    = tx_full_ff;
  assign tx_enable      = te_ff;
  assign preamble_queue = preamble_ff;
  assign break_request  = sbk_ff;

  // ==========================================================================
  // Idle line detection
  logic idle_pulse;
  logic idle_arm_ff;
  logic nxt_idle_arm;

  idle_line_detector u_idle (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .rx_tim     (rx_tim),
    .after_stop (ilt_ff),
    .long_char  (long_ff),
    .idle_seen  (idle_pulse)
  );

  // Re-armed only by a newly received character
  assign nxt_idle_arm = rx_char_valid | (idle_arm_ff & ~idle_pulse);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      idle_arm_ff <= 1'b0;
    end else begin
      idle_arm_ff <= nxt_idle_arm;
    end
  end

  // ==========================================================================
  // Status flags
  logic [NUM_FLAGS-1:0] flags;
  logic [NUM_FLAGS-1:0] flag_set;
  logic [NUM_FLAGS-1:0] flag_clr;
  logic                 tx_idle;

  // Complete means buffer empty and nothing shifting or queued
  // Request in this cycle must not re-set the flag it clears
  assign tx_idle = flags[FLAG_TXE] & ~nxt_tx_full & ~tx_active
                   & ~nxt_tx_pend;

  assign flag_set[FLAG_TXE]  = tx_load;
  assign flag_set[FLAG_TC]   = tx_idle;
  assign flag_set[FLAG_RXF]  = rx_char_valid;
  assign flag_set[FLAG_IDLE] = idle_pulse & idle_arm_ff;

  assign flag_clr[FLAG_TXE]  = data_wr;
  assign flag_clr[FLAG_TC]   = data_wr | te_rise | sbk_wr;
  assign flag_clr[FLAG_RXF]  = data_rd;
  assign flag_clr[FLAG_IDLE] = data_rd;

  // Reset presets the two transmit flags
  generate
    for (genvar i = 0; i < NUM_FLAGS; i++) begin : g_flag
      status_flag_cell #(
        .RESET_VAL (FLAGS_RESET[i])
      ) u_cell (
        .sys_clk (sys_clk),
        .rst     (rst),
        .set_evt (flag_set[i]),
        .arm_evt (status_rd),
        .clr_evt (flag_clr[i]),
        .flag    (flags[i])
      );
    end
  endgenerate

  // ==========================================================================
  // Interrupt status and mask
  logic [NUM_FLAGS-1:0] flags_d_ff;
  logic [NUM_FLAGS-1:0] evt_ff;
  logic [NUM_FLAGS-1:0] mask_ff;
  logic [NUM_FLAGS-1:0] flag_rise;
  logic [NUM_FLAGS-1:0] nxt_evt;
  logic [NUM_FLAGS-1:0] evt_w1c;

  assign flag_rise = flags & ~flags_d_ff;
  assign evt_w1c   = istat_wr ? reg_req.wdata[NUM_FLAGS-1:0]
                              : {NUM_FLAGS{1'b0}};
  // New event wins over a write-one clear
  assign nxt_evt   = flag_rise | (evt_ff & ~evt_w1c);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flags_d_ff <= FLAGS_RESET;
      evt_ff     <= {NUM_FLAGS{1'b0}};
    end else begin
      flags_d_ff <= flags;
      evt_ff     <= nxt_evt;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mask_ff <= {NUM_FLAGS{1'b0}};
    end else if (imask_wr) begin
      mask_ff <= reg_req.wdata[NUM_FLAGS-1:0];
    end
  end

  assign irq = |(evt_ff & mask_ff);

  // ==========================================================================
  // Read path, data one cycle after the strobe
  logic [7:0] status_word;
  logic [7:0] ctrl_word;
  logic [7:0] cfg_word;
  logic [7:0] istat_word;
  logic [7:0] imask_word;
  logic [7:0] rd_mux;
  logic [7:0] rd_data_ff;
  logic [7:0] nxt_rd_data;

  // Low four status bits belong to flags outside this block
  assign status_word = {flags, STATUS_LOW_ZERO};

  always_comb begin
    ctrl_word               = DATA_ZERO;
    ctrl_word[CTRL_TE_BIT]  = te_ff;
    ctrl_word[CTRL_SBK_BIT] = sbk_ff;
    cfg_word                = DATA_ZERO;
    cfg_word[CFG_ILT_BIT]   = ilt_ff;
    cfg_word[CFG_LONG_BIT]  = long_ff;
  end

  assign istat_word = {{(DATA_W-NUM_FLAGS){1'b0}}, evt_ff};
  assign imask_word = {{(DATA_W-NUM_FLAGS){1'b0}}, mask_ff};

  assign rd_mux = sel_status ? status_word :
                  sel_data   ? rx_data_ff  :
                  sel_ctrl   ? ctrl_word   :
                  sel_cfg    ? cfg_word    :
                  sel_istat  ? istat_word  :
                  sel_imask  ? imask_word  : DATA_ZERO;

  // Read data stands only in the cycle after the strobe
  assign nxt_rd_data = reg_req.rd ? rd_mux : DATA_ZERO;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_data_ff <= DATA_ZERO;
    end else begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  assign rd_data = rd_data_ff;

endmodule : serial_status_flags
`default_nettype wire

// *** hdl/serial_status_pkg.sv ***
// Constants, types and register map of the serial status flag block
package serial_status_pkg;

  // ==========================================================================
  // Widths
  localparam int ADDR_W    = 16;
  localparam int DATA_W    = 8;
  localparam int NUM_FLAGS = 4;
  localparam int IDLE_CNT_W = 4;

  // ==========================================================================
  // Register byte addresses
  localparam logic [ADDR_W-1:0] CTRL_TWO_ADDR  = 16'h3080;
  localparam logic [ADDR_W-1:0] STATUS_ADDR    = 16'h3084;
  localparam logic [ADDR_W-1:0] DATA_ADDR      = 16'h3088;
  localparam logic [ADDR_W-1:0] IRQ_STAT_ADDR  = 16'h308C;
  localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR  = 16'h3090;
  localparam logic [ADDR_W-1:0] CONFIG_ADDR    = 16'h3094;

  // ==========================================================================
  // Flag indices inside the flag vector; status bit = index + FLAG_LSB
  localparam int FLAG_IDLE = 0;
  localparam int FLAG_RXF  = 1;
  localparam int FLAG_TC   = 2;
  localparam int FLAG_TXE  = 3;
  localparam int FLAG_LSB  = 4;
  localparam logic [NUM_FLAGS-1:0] FLAGS_RESET = 4'hC;
  localparam logic [FLAG_LSB-1:0]  STATUS_LOW_ZERO = 4'h0;

  // ==========================================================================
  // Control two and config fields
  localparam int CTRL_SBK_BIT = 0;
  localparam int CTRL_TE_BIT  = 3;
  localparam int CFG_ILT_BIT  = 0;
  localparam int CFG_LONG_BIT = 1;

  // ==========================================================================
  // Idle threshold in bit times
  localparam logic [IDLE_CNT_W-1:0] IDLE_BITS_SHORT = 4'hA;
  localparam logic [IDLE_CNT_W-1:0] IDLE_BITS_LONG  = 4'hB;
  localparam logic [IDLE_CNT_W-1:0] IDLE_CNT_ONE    = 4'h1;
  localparam logic [IDLE_CNT_W-1:0] IDLE_CNT_ZERO   = 4'h0;

  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    IDLE_OFF,
    IDLE_COUNT,
    IDLE_DONE
  } idle_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;

  typedef struct packed {
    logic bit_tick;
    logic line;
    logic start_bit;
    logic stop_done;
  } rx_timing_t;

endpackage : serial_status_pkg

// *** hdl/status_flag_cell.sv ***
// One status flag with read-armed clearing sequence
`timescale 1ns/10ps
`default_nettype none
module status_flag_cell #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic sys_clk,   // Clock
  input  wire logic rst,       // Async reset, high
  input  wire logic set_evt,   // Hardware set
  input  wire logic arm_evt,   // Status register read
  input  wire logic clr_evt,   // Second access of the sequence
  output var  logic flag       // Flag value
);

  logic flag_ff;
  logic armed_ff;
  logic nxt_flag;
  logic nxt_armed;
  logic do_clear;

  // Clear only if armed by a read that saw the flag set
  assign do_clear  = clr_evt & armed_ff;
  // Set wins over a simultaneous clear
  assign nxt_flag  = set_evt | (flag_ff & ~do_clear);
  assign nxt_armed = arm_evt ? flag_ff : (armed_ff & ~clr_evt);
  assign flag      = flag_ff;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flag_ff  <= RESET_VAL;
      armed_ff <= 1'b0;
    end else begin
      flag_ff  <= nxt_flag;
      armed_ff <= nxt_armed;
    end
  end

endmodule : status_flag_cell
`default_nettype wire

// *** verification/serial_status_flags_asserts.sv ***
// Concurrent checks of the serial status flag block
`timescale 1ns/10ps
`default_nettype none
module serial_status_flags_asserts (
  input wire logic                        sys_clk,        // Clock
  input wire logic                        rst,            // Reset
  input wire serial_status_pkg::reg_req_t reg_req,        // Request
  input wire logic [7:0]                  rd_data,        // Read data
  input wire logic                        irq,            // Interrupt
  input wire logic                        tx_buf_full,    // Buffer held
  input wire logic                        tx_load,        // Shifter took
  input wire logic                        tx_active,      // Shifting
  input wire logic                        tx_enable,      // Tx enable
  input wire logic                        preamble_queue, // Preamble
  input wire logic                        break_request,  // Break
  input wire logic                        rx_char_valid   // Char in
);
  import serial_status_pkg::*;
  wire st_rd = reg_req.rd && reg_req.addr == STATUS_ADDR;
  wire d_wr  = reg_req.wr && reg_req.addr == DATA_ADDR;
  wire d_rd  = reg_req.rd && reg_req.addr == DATA_ADDR;
  wire c_wr  = reg_req.wr && reg_req.addr == CTRL_TWO_ADDR;
  wire m_wr  = reg_req.wr && reg_req.addr == IRQ_MASK_ADDR;
  wire quiet = !tx_active && !tx_buf_full && !break_request
               && !preamble_queue;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  // ==========================================================================
  // Clearing sequences
  sequence tx_arm_s;
    st_rd ##1 (rd_data[7:6] == 2'b11 && !tx_load) ##1 (d_wr && !tx_load)
    ##1 !tx_load ##1 st_rd;
  endsequence
  sequence rx_arm_s;
    st_rd ##1 (rd_data[5] && !rx_char_valid) ##1 (d_rd && !rx_char_valid)
    ##1 !rx_char_valid ##1 st_rd;
  endsequence
  sequence tc_arm_s;
    st_rd ##1 rd_data[6] ##1 (c_wr && reg_req.wdata[3] && !tx_enable)
    ##2 st_rd;
  endsequence

  // ==========================================================================
  // Checks
  rd_quiet_a: assert property (!reg_req.rd |=> rd_data == 8'h00)
    else $error("read data not zero");
  low_zero_a: assert property (st_rd |=> rd_data[3:0] == 4'h0)
    else $error("status low bits set");
  txe_load_a: assert property (
    tx_load ##1 !d_wr ##1 st_rd |=> rd_data[7])
    else $error("tx empty not set");
  tx_clear_a: assert property (
    tx_arm_s |=> rd_data[7:6] == 2'b00)
    else $error("tx flags not cleared");
  tc_idle_a: assert property (
    quiet [*3] ##0 st_rd |=> rd_data[7:6] == 2'b11)
    else $error("complete not set");
  tc_pre_a: assert property (tc_arm_s |=> !rd_data[6])
    else $error("complete not cleared");
  rxf_set_a: assert property (
    rx_char_valid ##1 !d_rd ##1 st_rd |=> rd_data[5])
    else $error("rx full not set");
  rxf_clear_a: assert property (rx_arm_s |=> !rd_data[5])
    else $error("rx full not cleared");
  preamble_a: assert property (
    c_wr && reg_req.wdata[3] && !tx_enable |=> preamble_queue && tx_enable)
    else $error("preamble not queued");
  irq_mask_a: assert property (m_wr && reg_req.wdata[3:0] == 4'h0 |=> !irq)
    else $error("masked irq high");
endmodule : serial_status_flags_asserts

bind serial_status_flags serial_status_flags_asserts serial_status_flags_asserts_i (
  .sys_clk, .rst, .reg_req, .rd_data, .irq, .tx_buf_full, .tx_load,
  .tx_active, .tx_enable, .preamble_queue, .break_request, .rx_char_valid);
`default_nettype wire

// *** verification/shifter_model.sv ***
// Transmit shifter stand-in driving load and activity
`timescale 1ns/10ps
`default_nettype none
module shifter_model (
  input  wire logic       sys_clk,        // Clock
  input  wire logic       rst,            // Reset
  input  wire logic [3:0] slow,           // Busy length
  input  wire logic       tx_buf_full,    // Buffer waiting
  input  wire logic       preamble_queue, // Preamble request
  input  wire logic       break_request,  // Break level
  output var  logic       tx_load,        // Buffer taken
  output var  logic       tx_active       // Shifting
);
  logic [4:0] cnt_ff;
  assign tx_active = cnt_ff != 5'h00;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_ff  <= 5'h00;
      tx_load <= 1'b0;
    end else begin
      tx_load <= 1'b0;
      if (cnt_ff != 5'h00) begin
        cnt_ff <= cnt_ff - 5'h01;
      end else if (tx_buf_full && !tx_load) begin
        tx_load <= 1'b1;
        cnt_ff  <= {1'b0, slow} + 5'h01;
      end else if (preamble_queue || break_request) begin
        cnt_ff <= {1'b0, slow} + 5'h01;
      end
    end
  end
endmodule : shifter_model
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking bench of the serial status flag block
`timescale 1ns/10ps
`default_nettype none
module tb;
  import serial_status_pkg::*;
  logic       sys_clk, rst, tx_load, tx_active, rx_char_valid, irq;
  logic       tx_buf_full, tx_enable, preamble_queue, break_request;
  logic [7:0] rd_data, tx_data, rx_char, got, ch;
  logic [3:0] slow;
  reg_req_t   reg_req;
  rx_timing_t rx_tim;
  int         num_errors, cmp_count;
  int         need [4] = '{1, 2, 10, 11};
  logic [7:0] cfgs [4] = '{8'h00, 8'h02, 8'h01, 8'h03};

  serial_status_flags serial_status_flags_i (
    .sys_clk, .rst, .reg_req, .rd_data, .irq, .tx_data, .tx_buf_full,
    .tx_load, .tx_active, .tx_enable, .preamble_queue, .break_request,
    .rx_char_valid, .rx_char, .rx_tim);
  shifter_model shifter_model_i (
    .sys_clk, .rst, .slow, .tx_buf_full, .preamble_queue, .break_request,
    .tx_load, .tx_active);

  // ==========================================================================
  // Helpers
  function automatic logic [7:0] st(input int t, c, r, i);
    return {t[0], c[0], r[0], i[0], 4'h0};
  endfunction : st
  task automatic chk(input string nm, input logic [7:0] e, v);
    cmp_count++;
    if (v !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, v);
    end
  endtask : chk
  task automatic acc(input logic w, r, input logic [15:0] a,
                     input logic [7:0] d);
    @(posedge sys_clk);
    reg_req <= '{a, d, w, r};
    @(posedge sys_clk);
    reg_req <= '{a, d, 1'b0, 1'b0};
    #1 got = rd_data;
  endtask : acc
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    acc(1'b1, 1'b0, a, d);
  endtask : wr
  task automatic rdc(input string nm, input logic [15:0] a,
                     input logic [7:0] e);
    acc(1'b0, 1'b1, a, 8'h00);
    chk(nm, e, got);
  endtask : rdc
  task automatic tick(input logic ln);
    @(posedge sys_clk) rx_tim <= {1'b1, ln, 2'b00};
    @(posedge sys_clk) rx_tim <= {1'b0, ln, 2'b00};
  endtask : tick
  task automatic frame(input logic [7:0] c);
    tick(1'b0);
    @(posedge sys_clk) rx_tim <= 4'b0010;
    for (int i = 0; i < 8; i++) tick(c[i]);
    tick(1'b1);
    @(posedge sys_clk) rx_tim <= 4'b0101;
    rx_char_valid <= 1'b1;
    rx_char       <= c;
    @(posedge sys_clk) rx_tim <= 4'b0100;
    rx_char_valid <= 1'b0;
  endtask : frame
  task automatic wait_idle;
    for (int i = 0; i < 64 && (tx_active || tx_buf_full); i++)
      @(posedge sys_clk);
    repeat (3) @(posedge sys_clk);
  endtask : wait_idle
  task automatic end_sim;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim

  // ==========================================================================
  // Clock, watchdog and tests
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    #200000;
    num_errors++;
    end_sim;
  end
  initial begin
    rst           = 1'b1;
    reg_req       = '0;
    rx_tim        = 4'b0100;
    rx_char_valid = 1'b0;
    rx_char       = 8'h00;
    slow          = 4'h3;
    void'($urandom(22));
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    rdc("status reset", STATUS_ADDR, st(1, 1, 0, 0));
    wr(STATUS_ADDR, 8'($urandom));
    rdc("status write", STATUS_ADDR, st(1, 1, 0, 0));
    repeat (3) begin
      @(posedge sys_clk) slow <= 4'($urandom_range(9, 1));
      ch = 8'($urandom);
      rdc("tx idle", STATUS_ADDR, st(1, 1, 0, 0));
      wr(DATA_ADDR, ch);
      chk("tx buffer", ch, tx_data);
      rdc("tx armed", STATUS_ADDR, st(0, 0, 0, 0));
      rdc("tx loaded", STATUS_ADDR, st(1, 0, 0, 0));
      wait_idle;
    end
    wr(CTRL_TWO_ADDR, 8'h00);
    rdc("tc before", STATUS_ADDR, st(1, 1, 0, 0));
    wr(CTRL_TWO_ADDR, 8'h08);
    rdc("tc preamble", STATUS_ADDR, st(1, 0, 0, 0));
    wait_idle;
    rdc("tc idle", STATUS_ADDR, st(1, 1, 0, 0));
    wr(CTRL_TWO_ADDR, 8'h09);
    rdc("tc break", STATUS_ADDR, st(1, 0, 0, 0));
    rdc("ctrl read", CTRL_TWO_ADDR, 8'h09);
    chk("break level", 8'h01, {7'h00, break_request});
    chk("tx enable", 8'h01, {7'h00, tx_enable});
    wr(CTRL_TWO_ADDR, 8'h08);
    wait_idle;
    rdc("tc done", STATUS_ADDR, st(1, 1, 0, 0));
    ch = 8'($urandom);
    frame(ch);
    rdc("rx full", STATUS_ADDR, st(1, 1, 1, 0));
    rdc("rx data", DATA_ADDR, ch);
    rdc("rx clear", STATUS_ADDR, st(1, 1, 0, 0));
    frame(~ch);
    rdc("rx late data", DATA_ADDR, ~ch);
    rdc("rx late", STATUS_ADDR, st(1, 1, 1, 0));
    rdc("rx data", DATA_ADDR, ~ch);
    for (int k = 0; k < 4; k++) begin
      wr(CONFIG_ADDR, cfgs[k]);
      rdc("cfg read", CONFIG_ADDR, cfgs[k]);
      frame(8'hFF);
      repeat (need[k] - 1) tick(1'b1);
      rdc("idle early", STATUS_ADDR, st(1, 1, 1, 0));
      tick(1'b1);
      rdc("idle set", STATUS_ADDR, st(1, 1, 1, 1));
      rdc("idle data", DATA_ADDR, 8'hFF);
      repeat (12) tick(1'b1);
      rdc("idle once", STATUS_ADDR, st(1, 1, 0, 0));
    end
    wr(IRQ_MASK_ADDR, 8'h00);
    wr(IRQ_STAT_ADDR, 8'h0F);
    chk("irq cleared", 8'h00, {7'h00, irq});
    frame(ch);
    chk("irq masked", 8'h00, {7'h00, irq});
    wr(IRQ_MASK_ADDR, 8'h02);
    chk("irq raised", 8'h01, {7'h00, irq});
    rdc("irq status", IRQ_STAT_ADDR, 8'h02);
    wr(IRQ_STAT_ADDR, 8'h02);
    chk("irq dropped", 8'h00, {7'h00, irq});
    rdc("unmapped", 16'h30FC, 8'h00);
    end_sim;
  end
endmodule : tb
`default_nettype wire
